// *** mip_cfg.svh ***
// Constants of the interrupt enable and priority block.
// Assumes the Avalon-MM master uses byte addresses, register index times four.
//
// Summary of operation
// - Global enable bit 7 gates every request
// - Enable bit 5 masks timer 2
// - Enable bit 4 masks serial port
// - Enable bit 3 masks timer 1
// - Enable bit 2 masks external 1
// - Enable bit 1 masks timer 0
// - Enable bit 0 masks external 0
// - High bit 7 raises external 3
// - High bit 6 raises external 2
// - High bit 5 raises timer 2
// - High bit 4 raises serial port
// - High bit 3 raises timer 1
// - High bit 2 raises external 1
// - High bit 1 raises timer 0
// - High bit 0 raises external 0
// - Low bit 5 raises timer 2
// - Low bit 4 raises serial port
// - Low bit 3 raises timer 1
// - Low bit 2 raises external 1
// - Low bit 1 raises timer 0
// - Low bit 0 raises external 0
// - External 2 and 3 own enables, low priority
// - Serial request from done flags, software clears
`ifndef MIP_CFG_SVH
`define MIP_CFG_SVH

// ****************************************
// Register indices
// ****************************************
`define MIP_IE_IDX 8'ha8
`define MIP_IPH_IDX 8'hb7
`define MIP_IP_IDX 8'hb8
`define MIP_XC_IDX 8'hc0
`define MIP_SER_IDX 8'hd0

// ****************************************
// Fields and reset values
// ****************************************
`define MIP_EA_BIT 7
`define MIP_IE_MASK 8'hbf
`define MIP_IP_MASK 8'h3f
`define MIP_SER_MASK 8'h03
`define MIP_XC_IT2 0
`define MIP_XC_IE2 1
`define MIP_XC_EX2 2
`define MIP_XC_PX2 3
`define MIP_XC_IT3 4
`define MIP_XC_IE3 5
`define MIP_XC_EX3 6
`define MIP_XC_PX3 7
`define MIP_SER_RX 0
`define MIP_SER_TX 1
`define MIP_REG_RST 8'h00
`define MIP_VEC_EXT2 3'h6
`define MIP_VEC_EXT3 3'h7

`endif

// *** mip_core_model.sv ***
// Behavioural core that takes the granted request and later ends its service.
// Assumes the bench opens ack_en for one grant and sets hold to at least 1.
`timescale 1ns/1ps
module mip_core_model (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic irq_req,
	input wire logic ack_en,
	input wire logic [7:0] hold,
	output logic irq_ack,
	output logic irq_ret
);
	logic busy_q;
	logic [7:0] cnt_q;

	// One service at a time; a long hold stands for a slow handler
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_ack <= 1'b0;
			irq_ret <= 1'b0;
			busy_q <= 1'b0;
			cnt_q <= 8'h00;
		end else begin
			irq_ack <= ack_en && irq_req && !busy_q;
			irq_ret <= busy_q && cnt_q == 8'h01;
			if (ack_en && irq_req && !busy_q) begin
				busy_q <= 1'b1;
				cnt_q <= hold;
			end else if (busy_q) begin
				cnt_q <= cnt_q - 8'h01;
				if (cnt_q == 8'h01) begin
					busy_q <= 1'b0;
				end
			end
		end
	end
endmodule : mip_core_model

// *** mip_irq_ctrl.sv ***
// Interrupt enable, priority and preemption logic for eight sources.
// Assumes sources are synchronous to ref_clk and the core pulses ack and ret.
`timescale 1ns/1ps
`include "mip_cfg.svh"
module mip_irq_ctrl (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic [9:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic ext0_req,
	input wire logic timer0_req,
	input wire logic ext1_req,
	input wire logic timer1_req,
	input wire logic timer2_req,
	input wire logic ext_irq2_input_n,
	input wire logic ext_irq3_input_n,
	input wire logic tx_done_set,
	input wire logic rx_done_set,
	input wire logic irq_ack,
	input wire logic irq_ret,
	output logic irq_req,
	output logic [2:0] irq_vec,
	output logic [1:0] irq_level
);

	// ****************************************
	// Functions
	// ****************************************
	function automatic logic hit(
		input logic [9:0] addr,
		input logic [7:0] idx
	);
		return addr == {idx, 2'b00};
	endfunction : hit

	// Strict compare keeps the lowest index on a tie
	function automatic mip_pkg::mip_grant_s pick_grant(
		input logic [7:0] pend,
		input logic [15:0] lv
	);
		mip_pkg::mip_grant_s g;
		g = '0;
		for (int i = 0; i < 8; i++) begin
			if (pend[i] && (!g.valid || lv[2*i+:2] > g.lvl)) begin
				g.valid = 1'b1;
				g.vec = 3'(i);
				g.lvl = lv[2*i+:2];
			end
		end
		return g;
	endfunction : pick_grant

	// ****************************************
	// State
	// ****************************************
	mip_pkg::mip_bus_e st_q;
	mip_pkg::mip_bus_e st_d;
	logic wait_q;
	logic wait_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic [7:0] ie_q;
	logic [7:0] ie_d;
	logic [7:0] hi_q;
	logic [7:0] hi_d;
	logic [7:0] lo_q;
	logic [7:0] lo_d;
	logic [7:0] xc_q;
	logic [7:0] xc_d;
	logic [7:0] ser_q;
	logic [7:0] ser_d;
	logic pin2_q;
	logic pin3_q;
	logic [3:0] isr_q;
	logic [3:0] isr_d;
	mip_pkg::mip_grant_s grant_q;
	mip_pkg::mip_grant_s grant_d;
	logic [7:0] rd_byte;
	logic wr_take;
	logic fall2;
	logic fall3;
	logic ext2_src;
	logic ext3_src;
	logic [7:0] src_vec;
	logic [7:0] en_vec;
	logic [7:0] lo_vec;
	logic [15:0] lvl_vec;
	logic [7:0] pend;
	mip_pkg::mip_grant_s best;
	logic act_valid;
	logic [1:0] act_lvl;

	// ****************************************
	// Register bus
	// ****************************************
	always_comb begin
		rd_byte = 8'h00;
		if (hit(avs_address, `MIP_IE_IDX)) begin
			rd_byte = ie_q;
		end else if (hit(avs_address, `MIP_IPH_IDX)) begin
			rd_byte = hi_q;
		end else if (hit(avs_address, `MIP_IP_IDX)) begin
			rd_byte = lo_q;
		end else if (hit(avs_address, `MIP_XC_IDX)) begin
			rd_byte = xc_q;
		end else if (hit(avs_address, `MIP_SER_IDX)) begin
			rd_byte = ser_q;
		end
	end

	// One wait state: request seen, then answered on the next edge
	always_comb begin
		st_d = st_q;
		wait_d = wait_q;
		rdata_d = rdata_q;
		case (st_q)
			mip_pkg::MIP_BUS_IDLE: begin
				if (avs_read || avs_write) begin
					st_d = mip_pkg::MIP_BUS_ANSWER;
					wait_d = 1'b0;
					rdata_d = avs_read ? {24'h000000, rd_byte} : 32'h00000000;
				end
			end
			mip_pkg::MIP_BUS_ANSWER: begin
				st_d = mip_pkg::MIP_BUS_IDLE;
				wait_d = 1'b1;
			end
			default: begin
				st_d = mip_pkg::MIP_BUS_IDLE;
				wait_d = 1'b1;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= mip_pkg::MIP_BUS_IDLE;
			wait_q <= 1'b1;
			rdata_q <= 32'h00000000;
		end else begin
			st_q <= st_d;
			wait_q <= wait_d;
			rdata_q <= rdata_d;
		end
	end

	assign avs_readdata = rdata_q;
	assign avs_waitrequest = wait_q;
	assign wr_take = avs_write && st_q == mip_pkg::MIP_BUS_ANSWER && avs_byteenable[0];

	// ****************************************
	// Source conditioning
	// ****************************************
	assign fall2 = pin2_q && !ext_irq2_input_n;
	assign fall3 = pin3_q && !ext_irq3_input_n;
	// Edge mode uses the flag, level mode follows the pin
	assign ext2_src = xc_q[`MIP_XC_IT2] ? xc_q[`MIP_XC_IE2] : !ext_irq2_input_n;
	assign ext3_src = xc_q[`MIP_XC_IT3] ? xc_q[`MIP_XC_IE3] : !ext_irq3_input_n;
	assign src_vec = {ext3_src, ext2_src, timer2_req,
		ser_q[`MIP_SER_TX] | ser_q[`MIP_SER_RX],
		timer1_req, ext1_req, timer0_req, ext0_req};
	assign en_vec = {xc_q[`MIP_XC_EX3], xc_q[`MIP_XC_EX2], ie_q[5:0]};
	assign lo_vec = {xc_q[`MIP_XC_PX3], xc_q[`MIP_XC_PX2], lo_q[5:0]};
	assign pend = {8{ie_q[`MIP_EA_BIT]}} & en_vec & src_vec;

	// ****************************************
	// Software registers and flags
	// ****************************************
	always_comb begin
		ie_d = ie_q;
		hi_d = hi_q;
		lo_d = lo_q;
		xc_d = xc_q;
		ser_d = ser_q;
		if (wr_take) begin
			if (hit(avs_address, `MIP_IE_IDX)) begin
				ie_d = avs_writedata[7:0] & `MIP_IE_MASK;
			end
			if (hit(avs_address, `MIP_IPH_IDX)) begin
				hi_d = avs_writedata[7:0];
			end
			if (hit(avs_address, `MIP_IP_IDX)) begin
				lo_d = avs_writedata[7:0] & `MIP_IP_MASK;
			end
			if (hit(avs_address, `MIP_XC_IDX)) begin
				xc_d = avs_writedata[7:0];
			end
			if (hit(avs_address, `MIP_SER_IDX)) begin
				ser_d = avs_writedata[7:0] & `MIP_SER_MASK;
			end
		end
		// Servicing an edge-mode source drops its flag
		if (irq_ack && grant_q.valid) begin
			if (grant_q.vec == `MIP_VEC_EXT2 && xc_q[`MIP_XC_IT2]) begin
				xc_d[`MIP_XC_IE2] = 1'b0;
			end
			if (grant_q.vec == `MIP_VEC_EXT3 && xc_q[`MIP_XC_IT3]) begin
				xc_d[`MIP_XC_IE3] = 1'b0;
			end
		end
		// Hardware set last, so it beats any clear in the same cycle
		if (fall2 && xc_q[`MIP_XC_IT2]) begin
			xc_d[`MIP_XC_IE2] = 1'b1;
		end
		if (fall3 && xc_q[`MIP_XC_IT3]) begin
			xc_d[`MIP_XC_IE3] = 1'b1;
		end
		if (rx_done_set) begin
			ser_d[`MIP_SER_RX] = 1'b1;
		end
		if (tx_done_set) begin
			ser_d[`MIP_SER_TX] = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			ie_q <= `MIP_REG_RST;
			hi_q <= `MIP_REG_RST;
			lo_q <= `MIP_REG_RST;
			xc_q <= `MIP_REG_RST;
			ser_q <= `MIP_REG_RST;
			pin2_q <= 1'b1;
			pin3_q <= 1'b1;
		end else begin
			ie_q <= ie_d;
			hi_q <= hi_d;
			lo_q <= lo_d;
			xc_q <= xc_d;
			ser_q <= ser_d;
			pin2_q <= ext_irq2_input_n;
			pin3_q <= ext_irq3_input_n;
		end
	end

	// ****************************************
	// Levels and arbitration
	// ****************************************
	// Level 3 when both bits set, 0 when neither
	for (genvar g = 0; g < 8; g++) begin : g_lvl
		assign lvl_vec[2*g+:2] = {hi_q[g], lo_vec[g]};
	end

	assign best = pick_grant(pend, lvl_vec);

	always_comb begin
		act_valid = 1'b0;
		act_lvl = 2'h0;
		for (int i = 0; i < 4; i++) begin
			if (isr_q[i]) begin
				act_valid = 1'b1;
				act_lvl = 2'(i);
			end
		end
	end

	always_comb begin
		grant_d = best;
		// Dropped in the ack cycle so the core never sees it twice
		grant_d.valid = best.valid && !irq_ack && (!act_valid || best.lvl > act_lvl);
		isr_d = isr_q;
		if (irq_ret && act_valid) begin
			isr_d[act_lvl] = 1'b0;
		end
		if (irq_ack && grant_q.valid) begin
			isr_d[grant_q.lvl] = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			grant_q <= '0;
			isr_q <= 4'h0;
		end else begin
			grant_q <= grant_d;
			isr_q <= isr_d;
		end
	end

	assign irq_req = grant_q.valid;
	assign irq_vec = grant_q.vec;
	assign irq_level = grant_q.lvl;

	// ****************************************
	// Checks
	// ****************************************
	logic [7:0] pend_p_q;
	logic [15:0] lvl_p_q;
	logic act_v_p_q;
	logic [1:0] act_l_p_q;
	mip_pkg::mip_grant_s chk_g;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			pend_p_q <= 8'h00;
			lvl_p_q <= 16'h0000;
			act_v_p_q <= 1'b0;
			act_l_p_q <= 2'h0;
		end else begin
			pend_p_q <= pend;
			lvl_p_q <= lvl_vec;
			act_v_p_q <= act_valid;
			act_l_p_q <= act_lvl;
		end
	end

	assign chk_g = pick_grant(pend_p_q, lvl_p_q);

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!arst_n);

	global_gate_a: assert property (!ie_q[`MIP_EA_BIT] |=> !irq_req)
		else $error("request passed with global enable clear");
	source_en_a: assert property (irq_req |-> pend_p_q[irq_vec] && $past(ie_q[7]))
		else $error("request from a masked source");
	level_map_a: assert property (irq_req |-> irq_level == lvl_p_q[2*irq_vec+:2])
		else $error("request level does not match priority bits");
	fixed_order_a: assert property (irq_req |-> irq_vec == chk_g.vec)
		else $error("wrong source chosen among pending");
	preempt_only_a: assert property (irq_req |-> !act_v_p_q || irq_level > act_l_p_q)
		else $error("request does not outrank service in progress");
	ack_drop_a: assert property (irq_req && irq_ack |=> !irq_req ##1 isr_q == $past(isr_q))
		else $error("request held after acknowledge");
	ser_set_a: assert property (tx_done_set |=> ser_q[`MIP_SER_TX])
		else $error("transmit done flag not set");
	ser_hold_a: assert property (ser_q[`MIP_SER_RX] && !wr_take |=> ser_q[`MIP_SER_RX])
		else $error("receive done flag lost without write");
	ext_edge_a: assert property (xc_q[`MIP_XC_IT2] && fall2 |=> xc_q[`MIP_XC_IE2])
		else $error("external 2 edge flag not set");
	bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest
		|=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("bus answer not after one wait state");

	nest_c: cover property (irq_req && irq_ack ##[1:20] irq_req && irq_level > $past(irq_level));
	serial_c: cover property (irq_req && irq_vec == 3'h4);
	ext3_c: cover property (irq_req && irq_vec == `MIP_VEC_EXT3 && irq_level == 2'h3);
	return_c: cover property (irq_ret && isr_q != 4'h0);

endmodule : mip_irq_ctrl

// *** mip_pkg.sv ***
// Types shared by the interrupt enable and priority block.
// Assumes constants come from mip_cfg.svh.
package mip_pkg;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic {
		MIP_BUS_IDLE,
		MIP_BUS_ANSWER
	} mip_bus_e;

	typedef struct packed {
		logic valid;
		logic [2:0] vec;
		logic [1:0] lvl;
	} mip_grant_s;

endpackage : mip_pkg

// *** tb_top.sv ***
// Self-checking bench of the interrupt enable and priority block.
// Assumes register indices from mip_cfg.svh and one wait state on the bus.
`timescale 1ns/1ps
`include "mip_cfg.svh"
module tb_top;
	logic ref_clk = 1'b0;
	logic arst_n = 1'b0;
	logic [9:0] avs_address = 10'h000;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'h1;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [7:0] src = 8'h00;
	logic tx_done_set = 1'b0;
	logic rx_done_set = 1'b0;
	logic irq_ack;
	logic irq_ret;
	logic irq_req;
	logic [2:0] irq_vec;
	logic [1:0] irq_level;
	logic ack_en = 1'b0;
	logic [31:0] rd;
	int bad_count = 0;
	int samples_checked = 0;
	int cycles = 0;

	always #25 ref_clk = ~ref_clk;

	mip_irq_ctrl dut (
		.ref_clk(ref_clk), .arst_n(arst_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .ext0_req(src[0]), .timer0_req(src[1]),
		.ext1_req(src[2]), .timer1_req(src[3]), .timer2_req(src[5]),
		.ext_irq2_input_n(~src[6]), .ext_irq3_input_n(~src[7]),
		.tx_done_set(tx_done_set), .rx_done_set(rx_done_set), .irq_ack(irq_ack),
		.irq_ret(irq_ret), .irq_req(irq_req), .irq_vec(irq_vec), .irq_level(irq_level)
	);

	mip_core_model core (
		.ref_clk(ref_clk), .arst_n(arst_n), .irq_req(irq_req), .ack_en(ack_en),
		.hold(8'h1e), .irq_ack(irq_ack), .irq_ret(irq_ret)
	);

	// ****************************************
	// Tasks
	// ****************************************
	task automatic print_verdict();
		if (bad_count == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : print_verdict

	// Request held until waitrequest is seen low at an edge
	task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
		int n;
		n = 0;
		@(posedge ref_clk);
		avs_address <= {idx, 2'b00};
		avs_writedata <= {24'h0, wd};
		avs_write <= wr;
		avs_read <= !wr;
		do begin
			@(posedge ref_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		if (n >= 50) begin
			bad_count++;
			$display("ERROR %0t bus answer missing", $time);
			print_verdict();
		end
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus

	task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %0t read %h expected %h", $time, got, exp);
		end
	endtask : check_val

	task automatic rreg(input logic [7:0] idx, input logic [7:0] exp);
		bus(1'b0, idx, 8'h00);
		check_val(rd, {24'h0, exp});
	endtask : rreg

	// Settling time covers register update plus the registered grant
	task automatic check_irq(input logic r, input logic [2:0] v, input logic [1:0] l);
		repeat (3) @(posedge ref_clk);
		@(negedge ref_clk);
		samples_checked++;
		if (irq_req !== r || (r && (irq_vec !== v || irq_level !== l))) begin
			bad_count++;
			$display("ERROR %0t grant %b %h %h expected %b %h %h", $time, irq_req,
				irq_vec, irq_level, r, v, l);
		end
	endtask : check_irq

	task automatic pulse(input logic tx);
		@(posedge ref_clk);
		tx_done_set <= tx;
		rx_done_set <= !tx;
		@(posedge ref_clk);
		tx_done_set <= 1'b0;
		rx_done_set <= 1'b0;
	endtask : pulse

	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			print_verdict();
		end
	end

	// ****************************************
	// Tests
	// ****************************************
	initial begin
		int n;
		repeat (4) @(posedge ref_clk);
		arst_n <= 1'b1;
		rreg(`MIP_IE_IDX, 8'h00);
		rreg(`MIP_IPH_IDX, 8'h00);
		rreg(`MIP_IP_IDX, 8'h00);
		bus(1'b1, 8'h10, 8'hff);
		rreg(8'h10, 8'h00);
		bus(1'b1, `MIP_IE_IDX, 8'hff);
		rreg(`MIP_IE_IDX, 8'hbf);
		bus(1'b1, `MIP_IP_IDX, 8'hff);
		rreg(`MIP_IP_IDX, 8'h3f);
		bus(1'b1, `MIP_IPH_IDX, 8'hff);
		rreg(`MIP_IPH_IDX, 8'hff);
		bus(1'b1, `MIP_IP_IDX, 8'h00);
		bus(1'b1, `MIP_IPH_IDX, 8'h00);
		src <= 8'h3f;
		pulse(1'b0);
		rreg(`MIP_SER_IDX, 8'h01);
		check_irq(1'b1, 3'h0, 2'h0);
		bus(1'b1, `MIP_IE_IDX, 8'h3f);
		check_irq(1'b0, 3'h0, 2'h0);
		for (int v = 0; v < 6; v++) begin
			bus(1'b1, `MIP_IE_IDX, 8'(8'h80 | (1 << v)));
			check_irq(1'b1, v[2:0], 2'h0);
			bus(1'b1, `MIP_IE_IDX, 8'(8'h80 | (8'h3f & ~(1 << v))));
			bus(1'b1, `MIP_IPH_IDX, 8'(1 << v));
			check_irq(1'b1, (v == 0) ? 3'h1 : 3'h0, 2'h0);
			bus(1'b1, `MIP_IE_IDX, 8'hbf);
			check_irq(1'b1, v[2:0], 2'h2);
			bus(1'b1, `MIP_IPH_IDX, 8'h00);
			bus(1'b1, `MIP_IP_IDX, 8'(1 << v));
			check_irq(1'b1, v[2:0], 2'h1);
			bus(1'b1, `MIP_IPH_IDX, 8'(1 << v));
			check_irq(1'b1, v[2:0], 2'h3);
			bus(1'b1, `MIP_IPH_IDX, 8'h00);
			bus(1'b1, `MIP_IP_IDX, 8'h00);
			bus(1'b1, `MIP_IE_IDX, 8'(8'h80 | (8'h3f & ~((1 << v) - 1))));
			check_irq(1'b1, v[2:0], 2'h0);
		end
		bus(1'b1, `MIP_SER_IDX, 8'h00);
		bus(1'b1, `MIP_IE_IDX, 8'h90);
		check_irq(1'b0, 3'h0, 2'h0);
		pulse(1'b1);
		rreg(`MIP_SER_IDX, 8'h02);
		check_irq(1'b1, 3'h4, 2'h0);
		bus(1'b1, `MIP_SER_IDX, 8'h00);
		bus(1'b1, `MIP_IE_IDX, 8'h80);
		src <= 8'hc0;
		check_irq(1'b0, 3'h0, 2'h0);
		bus(1'b1, `MIP_XC_IDX, 8'h44);
		check_irq(1'b1, 3'h6, 2'h0);
		bus(1'b1, `MIP_IPH_IDX, 8'h80);
		check_irq(1'b1, 3'h7, 2'h2);
		bus(1'b1, `MIP_IPH_IDX, 8'h40);
		check_irq(1'b1, 3'h6, 2'h2);
		bus(1'b1, `MIP_IPH_IDX, 8'h00);
		bus(1'b1, `MIP_XC_IDX, 8'hc4);
		check_irq(1'b1, 3'h7, 2'h1);
		bus(1'b1, `MIP_XC_IDX, 8'h00);
		// Edge mode on external 2: pin fall sets the flag
		src <= 8'h00;
		bus(1'b1, `MIP_XC_IDX, 8'h05);
		src <= 8'h40;
		rreg(`MIP_XC_IDX, 8'h07);
		check_irq(1'b1, 3'h6, 2'h0);
		bus(1'b1, `MIP_XC_IDX, 8'h00);
		// Slow core: an equal level waits, a higher one preempts
		bus(1'b1, `MIP_IE_IDX, 8'hbf);
		bus(1'b1, `MIP_IP_IDX, 8'h08);
		src <= 8'h02;
		ack_en <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (irq_ack !== 1'b1 && n < 20);
		ack_en <= 1'b0;
		check_val({31'h0, irq_ack}, 32'h1);
		src <= 8'h03;
		check_irq(1'b0, 3'h0, 2'h0);
		src <= 8'h0b;
		check_irq(1'b1, 3'h3, 2'h1);
		print_verdict();
	end
endmodule : tb_top
